// ===== include/srrp_cfg.svh
`ifndef SRRP_CFG_SVH
`define SRRP_CFG_SVH

// Command byte layout
`define SRRP_CMD_DIR_BIT 7
`define SRRP_CMD_IDX_MSB 6
`define SRRP_CMD_LAST_BIT 3'h7

// Register indices
`define SRRP_PHASE_A_ACTIVE_ENERGY_IDX 7'h01
`define SRRP_PHASE_B_ACTIVE_ENERGY_IDX 7'h02
`define SRRP_PHASE_C_ACTIVE_ENERGY_IDX 7'h03
`define SRRP_PHASE_A_REACTIVE_ENERGY_IDX 7'h04
`define SRRP_PHASE_B_REACTIVE_ENERGY_IDX 7'h05

// Widths and reset values
`define SRRP_ENERGY_BITS 5'h10
`define SRRP_DEFAULT_BITS 5'h08
`define SRRP_ENERGY_RESET 16'h0000
`define SRRP_MEM_WORDS 8

`endif

// ===== include/srrp_pkg.sv
package srrp_pkg;

	typedef enum logic [1:0] {
		SRRP_ST_CMD,
		SRRP_ST_LOAD,
		SRRP_ST_READ,
		SRRP_ST_WRITE
	} srrp_state_t;

	typedef struct packed {
		logic wr;
		logic [6:0] target_reg_index;
	} srrp_cmd_t;

	typedef struct packed {
		logic valid;
		logic [6:0] target_reg_index;
		logic [15:0] value;
	} srrp_upd_t;

	typedef struct packed {
		logic strobe;
		logic [6:0] target_reg_index;
		logic [15:0] value;
	} srrp_wr_t;

endpackage

// ===== src/srrp_energy_mem.sv
`timescale 1ns/1ns
`include "srrp_cfg.svh"

module srrp_energy_mem (
	// Clock, reset and enable
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	// Update port from the metering core
	input wire logic wr_en_i,
	input wire logic [2:0] wr_addr_i,
	input wire logic [15:0] wr_data_i,
	// Registered read port
	input wire logic [2:0] rd_addr_i,
	output logic [15:0] rd_data_o
);
	logic [15:0] mem_reg [`SRRP_MEM_WORDS];

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < `SRRP_MEM_WORDS; i++) begin
				mem_reg[i] <= `SRRP_ENERGY_RESET;
			end
		end else if (ce_i && wr_en_i) begin
			mem_reg[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_data_o <= `SRRP_ENERGY_RESET;
		end else if (ce_i) begin
			rd_data_o <= mem_reg[rd_addr_i];
		end
	end
endmodule // srrp_energy_mem

// ===== src/srrp_serial_port.sv
`timescale 1ns/1ns
`include "srrp_cfg.svh"

module srrp_serial_port (
	// Clock, reset, enable
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	input wire logic CE_I,
	// Serial pins
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic DIN_I,
	output logic DOUT_O,
	output logic DOUT_OE_N_O,
	// Metering core side
	input wire srrp_pkg::srrp_upd_t ENERGY_UPD_I,
	output srrp_pkg::srrp_wr_t REG_WR_O,
	output logic BUSY_O
);
	import srrp_pkg::*;

	function automatic logic is_energy(input logic [6:0] idx);
		return (idx >= `SRRP_PHASE_A_ACTIVE_ENERGY_IDX) &&
			(idx <= `SRRP_PHASE_B_REACTIVE_ENERGY_IDX);
	endfunction

	function automatic logic [4:0] reg_bits(input logic [6:0] idx);
		return is_energy(idx) ? `SRRP_ENERGY_BITS : `SRRP_DEFAULT_BITS;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection
	logic [1:0] sclk_sync_reg;
	logic [1:0] cs_sync_reg;
	logic [1:0] din_sync_reg;
	logic sclk_d_reg;
	logic cs_d_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic cs_fall;
	logic cs_low;

	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sclk_sync_reg <= 2'h3;
			cs_sync_reg <= 2'h3;
			din_sync_reg <= 2'h0;
			sclk_d_reg <= 1'b1;
			cs_d_reg <= 1'b1;
		end else if (CE_I) begin
			sclk_sync_reg <= {sclk_sync_reg[0], SCLK_I};
			cs_sync_reg <= {cs_sync_reg[0], CS_N_I};
			din_sync_reg <= {din_sync_reg[0], DIN_I};
			sclk_d_reg <= sclk_sync_reg[1];
			cs_d_reg <= cs_sync_reg[1];
		end
	end

	assign sclk_rise = CE_I && sclk_sync_reg[1] && !sclk_d_reg;
	assign sclk_fall = CE_I && !sclk_sync_reg[1] && sclk_d_reg;
	assign cs_rise = CE_I && cs_sync_reg[1] && !cs_d_reg;
	assign cs_fall = CE_I && !cs_sync_reg[1] && cs_d_reg;
	assign cs_low = !cs_sync_reg[1];

	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [6:0] rd_idx_reg;
	logic [15:0] mem_rd_data;
	logic upd_hit;

	assign upd_hit = ENERGY_UPD_I.valid && is_energy(ENERGY_UPD_I.target_reg_index);

	srrp_energy_mem u_mem (
		.clk_i(CORE_CLK_I),
		.resetn_i(RESETN_I),
		.ce_i(CE_I),
		.wr_en_i(upd_hit),
		.wr_addr_i(ENERGY_UPD_I.target_reg_index[2:0]),
		.wr_data_i(ENERGY_UPD_I.value),
		.rd_addr_i(rd_idx_reg[2:0]),
		.rd_data_o(mem_rd_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Command capture and sequencing
	srrp_state_t state_reg;
	srrp_cmd_t cmd_reg;
	logic [7:0] cmd_next;
	logic [2:0] cmd_cnt_reg;
	logic [4:0] bits_left_reg;
	logic [15:0] shift_reg;
	logic load_wait_reg;

	assign cmd_next = {cmd_reg[6:0], din_sync_reg[1]};

	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_reg <= SRRP_ST_CMD;
			cmd_reg <= '0;
			cmd_cnt_reg <= 3'h0;
			rd_idx_reg <= 7'h00;
			load_wait_reg <= 1'b0;
		end else if (CE_I) begin
			if (cs_fall || cs_rise) begin
				state_reg <= SRRP_ST_CMD;
				cmd_cnt_reg <= 3'h0;
			end else if (cs_low) begin
				unique case (state_reg)
					SRRP_ST_CMD: begin
						if (sclk_fall) begin
							cmd_reg <= cmd_next;
							cmd_cnt_reg <= cmd_cnt_reg + 3'h1;
							if (cmd_cnt_reg == `SRRP_CMD_LAST_BIT) begin
								rd_idx_reg <= cmd_next[`SRRP_CMD_IDX_MSB:0];
								load_wait_reg <= 1'b1;
								if (cmd_next[`SRRP_CMD_DIR_BIT]) begin
									state_reg <= SRRP_ST_WRITE;
								end else begin
									state_reg <= SRRP_ST_LOAD;
								end
							end
						end
					end
					SRRP_ST_LOAD: begin
						load_wait_reg <= 1'b0;
						if (!load_wait_reg) begin
							state_reg <= SRRP_ST_READ;
						end
					end
					SRRP_ST_READ: begin
						if (sclk_fall && bits_left_reg == 5'h00) begin
							state_reg <= SRRP_ST_CMD;
						end
					end
					SRRP_ST_WRITE: begin
						if (sclk_fall && bits_left_reg == 5'h01) begin
							state_reg <= SRRP_ST_CMD;
						end
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift buffer
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			shift_reg <= 16'h0000;
			bits_left_reg <= 5'h00;
		end else if (CE_I) begin
			if (state_reg == SRRP_ST_CMD && sclk_fall && cmd_cnt_reg == `SRRP_CMD_LAST_BIT) begin
				bits_left_reg <= reg_bits(cmd_next[`SRRP_CMD_IDX_MSB:0]);
				shift_reg <= 16'h0000;
			end else if (state_reg == SRRP_ST_LOAD && !load_wait_reg) begin
				shift_reg <= is_energy(rd_idx_reg) ? mem_rd_data : 16'h0000;
			end else if (state_reg == SRRP_ST_READ && sclk_rise && bits_left_reg != 5'h00) begin
				shift_reg <= {shift_reg[14:0], 1'b0};
				bits_left_reg <= bits_left_reg - 5'h01;
			end else if (state_reg == SRRP_ST_WRITE && sclk_fall && cs_low) begin
				shift_reg <= {shift_reg[14:0], din_sync_reg[1]};
				bits_left_reg <= bits_left_reg - 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Serial output driver
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			DOUT_O <= 1'b0;
			DOUT_OE_N_O <= 1'b1;
		end else if (CE_I) begin
			if (cs_rise || cs_fall || !cs_low) begin
				DOUT_OE_N_O <= 1'b1;
			end else if (state_reg == SRRP_ST_READ && sclk_rise && bits_left_reg != 5'h00) begin
				DOUT_O <= shift_reg[15];
				DOUT_OE_N_O <= 1'b0;
			end else if (state_reg == SRRP_ST_READ && sclk_fall && bits_left_reg == 5'h00) begin
				DOUT_OE_N_O <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write hand-off and status
	always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			REG_WR_O <= '0;
			BUSY_O <= 1'b0;
		end else if (CE_I) begin
			REG_WR_O.strobe <= 1'b0;
			BUSY_O <= state_reg != SRRP_ST_CMD || cmd_cnt_reg != 3'h0;
			if (state_reg == SRRP_ST_WRITE && sclk_fall && cs_low && bits_left_reg == 5'h01) begin
				REG_WR_O.strobe <= 1'b1;
				REG_WR_O.target_reg_index <= cmd_reg.target_reg_index;
				REG_WR_O.value <= {shift_reg[14:0], din_sync_reg[1]};
			end
		end
	end
endmodule // srrp_serial_port

// ===== sim/srrp_serial_port_properties.sv
`timescale 1ns/1ns
module srrp_chk (
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RESETN_I,
	// Serial pins
	input wire logic SCLK_I,
	input wire logic CS_N_I,
	input wire logic DOUT_O,
	input wire logic DOUT_OE_N_O,
	// Core side
	input wire srrp_pkg::srrp_wr_t REG_WR_O,
	input wire logic BUSY_O
);
	import srrp_pkg::*;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESETN_I);
	sequence cs_idle; CS_N_I [*7]; endsequence
	sequence oe_on; $fell(DOUT_OE_N_O); endsequence
	sequence bit_shift; !DOUT_OE_N_O && $past(!DOUT_OE_N_O) && $changed(DOUT_O); endsequence
	chk_oe_cs_idle: assert property (cs_idle |-> DOUT_OE_N_O) else $error("drive while idle");
	chk_busy_cs_idle: assert property (cs_idle |-> !BUSY_O) else $error("busy while idle");
	chk_oe_on_rise: assert property (oe_on |-> $past(SCLK_I, 2) && !$past(CS_N_I, 2))
		else $error("drive start off rise");
	chk_oe_held: assert property (oe_on |=> !DOUT_OE_N_O [*4]) else $error("drive too short");
	chk_dout_rise: assert property (bit_shift |-> $past(SCLK_I, 2)) else $error("bit off rise");
	chk_oe_release: assert property ($rose(DOUT_OE_N_O) |-> !$past(SCLK_I, 2) || $past(CS_N_I, 2))
		else $error("release off fall");
	chk_strobe_pulse: assert property (REG_WR_O.strobe |=> !REG_WR_O.strobe) else $error("long strobe");
	chk_strobe_fall: assert property (REG_WR_O.strobe |-> !$past(SCLK_I, 3) && !$past(CS_N_I, 4))
		else $error("strobe off fall");
	chk_write_quiet: assert property (REG_WR_O.strobe |-> DOUT_OE_N_O) else $error("drive on write");
endmodule // srrp_chk
bind srrp_serial_port srrp_chk srrp_chk_inst (.CORE_CLK_I, .RESETN_I, .SCLK_I, .CS_N_I, .DOUT_O,
	.DOUT_OE_N_O, .REG_WR_O, .BUSY_O);

// ===== sim/srrp_host_model.sv
`timescale 1ns/1ns
module srrp_host_model (
	// Serial pins
	output logic sclk_o,
	output logic cs_n_o,
	output logic din_o,
	input wire logic dout_i,
	// Received word
	output logic [15:0] word_o,
	output logic done_o
);
	initial begin
		sclk_o = 0;
		cs_n_o = 1;
		din_o = 1;
		word_o = 0;
		done_o = 0;
	end
	// Data changes on the rise so it is settled at the sampling fall
	task automatic bit_cyc(input logic b);
		#80 sclk_o = 1;
		din_o = b;
		#80 word_o = {word_o[14:0], dout_i};
		sclk_o = 0;
	endtask
	// Command, then data bits; stop after cut bits to abort
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, input int n, input int cut);
		// Pins move 2 ns after a core clock edge, never on it
		#2 cs_n_o = 0;
		for (int i = 7; i >= 0; i--) bit_cyc(cmd[i]);
		#80 word_o = 0;
		for (int i = n - 1; i >= n - cut; i--) bit_cyc(wd[i]);
		#80 cs_n_o = 1;
		din_o = ~din_o;
		if (cut == n && !cmd[7]) done_o = ~done_o;
		#1198;
	endtask
endmodule // srrp_host_model

// ===== sim/serial_register_read_port_tb.sv
`timescale 1ns/1ns
module serial_register_read_port_tb;
	import srrp_pkg::*;
	logic clk = 0;
	logic resetn = 0;
	logic ce = 1'b1;
	srrp_upd_t upd = '0;
	srrp_wr_t wr;
	logic sclk, cs_n, din, dout, oe_n, busy, done;
	logic [15:0] word, v;
	logic [15:0] val [1:5];
	wire logic sdo = oe_n ? 1'bz : dout;
	logic [15:0] rexp [$];
	logic [22:0] wexp [$];
	int errors = 0;
	int cmp_count = 0;
	int seed = 32'h2194;
	initial forever #5 clk = ~clk;
	srrp_serial_port srrp_serial_port_inst (.CORE_CLK_I(clk), .RESETN_I(resetn), .CE_I(ce),
		.SCLK_I(sclk), .CS_N_I(cs_n), .DIN_I(din), .DOUT_O(dout), .DOUT_OE_N_O(oe_n),
		.ENERGY_UPD_I(upd), .REG_WR_O(wr), .BUSY_O(busy));
	srrp_host_model srrp_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
		.dout_i(sdo), .word_o(word), .done_o(done));
	task automatic check(input string what, input logic [22:0] e, input logic [22:0] s);
		cmp_count++;
		if (e !== s) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic give_verdict;
		check("leftover", 23'h0, 23'(rexp.size() + wexp.size()));
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic load(input logic [6:0] idx, input logic [15:0] d);
		@(posedge clk) upd <= '{1'b1, idx, d};
		@(posedge clk) upd <= '0;
	endtask
	task automatic rd(input int k, input int n, input logic [15:0] e);
		rexp.push_back(e);
		srrp_host_model_inst.xfer({1'b0, 7'(k)}, 16'h0, n, n);
	endtask
	always @(done) if ($time > 0) check("read", rexp.size() ? rexp.pop_front() : 'x, word);
	always @(negedge clk) if (wr.strobe)
		check("write", wexp.size() ? wexp.pop_front() : 'x, {wr.target_reg_index, wr.value});
	initial begin
		#500000 errors++;
		give_verdict;
	end
	initial begin
		repeat (4) @(posedge clk);
		resetn <= 1;
		repeat (6) @(posedge clk);
		for (int k = 1; k <= 5; k++) rd(k, 16, 16'h0);
		rd(0, 8, 16'h0);
		load(7'h06, 16'hFFFF);
		rd(6, 8, 16'h0);
		for (int k = 1; k <= 5; k++) begin
			v = 16'($random(seed));
			val[k] = 16'($random(seed));
			load(7'(k), v);
			fork
				rd(k, 16, v);
				#2000 load(7'(k), val[k]);
			join
		end
		for (int k = 1; k <= 5; k++) begin
			v = 16'($random(seed));
			wexp.push_back({7'(k), v});
			srrp_host_model_inst.xfer({1'b1, 7'(k)}, v, 16, 16);
			rd(k, 16, val[k]);
		end
		srrp_host_model_inst.xfer(8'h02, 16'h0, 16, 4);
		srrp_host_model_inst.xfer(8'h83, 16'hA5A5, 16, 12);
		rd(2, 16, val[2]);
		v = 16'($random(seed));
		wexp.push_back({7'h06, 8'h00, v[7:0]});
		srrp_host_model_inst.xfer(8'h86, v, 8, 8);
		// Update offered while the enable is low must be dropped
		ce <= 1'b0;
		load(7'h01, ~val[1]);
		ce <= 1'b1;
		rd(1, 16, val[1]);
		repeat (20) @(posedge clk);
		check("idle", 23'h1, 23'({busy, oe_n}));
		give_verdict;
	end
endmodule // serial_register_read_port_tb
